// File: hdl/reset_pkg.sv
// Package with constants and carrier types for the reset combiner and power-up delay timer.
package reset_pkg;
    localparam int unsigned CLK_FREQ_HZ     = 250_000_000;
    localparam int unsigned PUD_TIME_MS     = 64;
    localparam int unsigned PUD_CYCLES      = (CLK_FREQ_HZ / 1000) * PUD_TIME_MS;
    localparam int unsigned TICK_DIV        = 250;
    localparam int unsigned PUD_TICKS       = PUD_CYCLES / TICK_DIV;
    localparam int unsigned TICK_W          = 8;
    localparam int unsigned PUD_W           = 17;
    localparam int unsigned NUM_SOURCES     = 10;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

    typedef enum logic [3:0] {
        SRC_POWER_ON,
        SRC_BROWNOUT,
        SRC_LP_BROWNOUT,
        SRC_MASTER_CLEAR,
        SRC_WATCHDOG,
        SRC_RESET_INSTR,
        SRC_STACK_OVER,
        SRC_STACK_UNDER,
        SRC_PROG_EXIT,
        SRC_PUD_TIMER
    } reset_source_t;

    typedef struct packed {
        logic power_on_detect;
        logic brownout_detect;
        logic low_power_brownout_detect;
        logic external_master_clear;
        logic watchdog_reset;
        logic reset_instruction;
        logic stack_overflow;
        logic stack_underflow;
        logic programming_exit;
    } reset_requests_t;
endpackage

// File: hdl/power_up_delay_timer.sv
// Power-up delay timer counting slow ticks until the start-up delay expires.
`timescale 1ns/1ps
module power_up_delay_timer
    import reset_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic tick,
    input  wire logic restart,
    input  wire logic enable,
    output logic      running
);
    typedef enum {PUD_IDLE, PUD_COUNT, PUD_DONE} pud_state_t;

    pud_state_t       state_reg;
    pud_state_t       state_next;
    logic [PUD_W-1:0] count_reg;
    logic [PUD_W-1:0] count_next;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            PUD_IDLE: begin
                count_next = '0;
                // Counting begins only once both supply requests have gone away.
                if (!restart) begin
                    state_next = enable ? PUD_COUNT : PUD_DONE;
                end
            end
            PUD_COUNT: begin
                if (restart) begin
                    state_next = PUD_IDLE;
                    count_next = '0;
                end else if (tick) begin
                    if (count_reg == PUD_W'(PUD_TICKS - 1)) begin
                        state_next = PUD_DONE;
                    end else begin
                        count_next = count_reg + PUD_W'(1);
                    end
                end
            end
            PUD_DONE: begin
                if (restart) begin
                    state_next = PUD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg <= PUD_IDLE;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // A cleared counter is not yet done, so reset holds until DONE is reached.
    assign running = (state_reg != PUD_DONE);
endmodule

// File: hdl/reset_combiner.sv
// Reset source combiner that extends supply resets with the power-up delay.
//
// Functional notes
// - Any of the nine reset sources asserts the core reset.
// - Core stays in reset while the power-on detector reports low supply.
// - Enabled power-up delay lasts a nominal 64 ms after supply resets.
// - Core stays in reset while the power-up delay timer is counting.
// - Delay is enabled only when its disable bit is low; high bypasses it.
// - Delay starts only after power-on and brown-out both released.
// - Reset releases only when delay, brown-out and master clear all released.
// - Low-power brown-out is ORed with brown-out into one brown-out signal.
`timescale 1ns/1ps
module reset_combiner
    import reset_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire reset_requests_t   requests,
    input  wire logic              power_up_delay_disable_n,
    output logic                   core_reset,
    output logic [NUM_SOURCES-1:0] reset_cause
);
    // Requests arrive from analog detectors, pins and internal requesters, and each passes two flops.
    reset_requests_t sync1_reg;
    reset_requests_t sync1_next;
    reset_requests_t sync2_reg;
    reset_requests_t sync2_next;
    logic            cfg_sync1_reg;
    logic            cfg_sync2_reg;
    logic            cfg_sync1_next;
    logic            cfg_sync2_next;

    always_comb begin
        sync1_next     = requests;
        sync2_next     = sync1_reg;
        cfg_sync1_next = power_up_delay_disable_n;
        cfg_sync2_next = cfg_sync1_reg;
    end

    // The synchroniser resets to the asserted state so the core is held from reset.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync1_reg     <= '1;
            sync2_reg     <= '1;
            cfg_sync1_reg <= 1'b1;
            cfg_sync2_reg <= 1'b1;
        end else begin
            sync1_reg     <= sync1_next;
            sync2_reg     <= sync2_next;
            cfg_sync1_reg <= cfg_sync1_next;
            cfg_sync2_reg <= cfg_sync2_next;
        end
    end

    logic brownout_any;
    logic supply_request;
    logic pud_running;
    logic pud_enable;

    assign brownout_any   = sync2_reg.brownout_detect | sync2_reg.low_power_brownout_detect;
    assign supply_request = sync2_reg.power_on_detect | brownout_any;
    assign pud_enable     = !cfg_sync2_reg;

    // Slow timebase; keeping the delay counter narrow costs one small prescaler.
    logic [TICK_W-1:0] tick_cnt_reg;
    logic [TICK_W-1:0] tick_cnt_next;
    logic              tick;

    always_comb begin
        tick          = (tick_cnt_reg == TICK_LAST);
        tick_cnt_next = tick ? '0 : tick_cnt_reg + TICK_W'(1);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    power_up_delay_timer u_pud (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tick    (tick),
        .restart (supply_request),
        .enable  (pud_enable),
        .running (pud_running)
    );

    logic [NUM_SOURCES-1:0] cause_vec;

    always_comb begin
        cause_vec                   = '0;
        cause_vec[SRC_POWER_ON]     = sync2_reg.power_on_detect;
        cause_vec[SRC_BROWNOUT]     = brownout_any;
        cause_vec[SRC_LP_BROWNOUT]  = sync2_reg.low_power_brownout_detect;
        cause_vec[SRC_MASTER_CLEAR] = sync2_reg.external_master_clear;
        cause_vec[SRC_WATCHDOG]     = sync2_reg.watchdog_reset;
        cause_vec[SRC_RESET_INSTR]  = sync2_reg.reset_instruction;
        cause_vec[SRC_STACK_OVER]   = sync2_reg.stack_overflow;
        cause_vec[SRC_STACK_UNDER]  = sync2_reg.stack_underflow;
        cause_vec[SRC_PROG_EXIT]    = sync2_reg.programming_exit;
        cause_vec[SRC_PUD_TIMER]    = pud_running;
    end

    logic                   core_reset_reg;
    logic                   core_reset_next;
    logic [NUM_SOURCES-1:0] cause_reg;
    logic [NUM_SOURCES-1:0] cause_next;

    always_comb begin
        core_reset_next = |cause_vec;
        cause_next      = cause_vec;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            core_reset_reg <= 1'b1;
            cause_reg      <= '0;
        end else begin
            core_reset_reg <= core_reset_next;
            cause_reg      <= cause_next;
        end
    end

    assign core_reset  = core_reset_reg;
    assign reset_cause = cause_reg;
endmodule

// File: tb/reset_request_model.sv
// Behavioural model of the supply monitors, reset pin and internal reset requesters.
`timescale 1ns/1ps
module reset_request_model
    import reset_pkg::*;
(
    input  wire logic       clk_sys,
    output reset_requests_t requests
);
    initial requests = '1;
    // Requests move just after a falling edge, so the sync flops never race them.
    task automatic apply(input reset_requests_t r, input int n);
        @(negedge clk_sys);
        requests = r;
        repeat (n) @(negedge clk_sys);
    endtask
endmodule

// File: tb/reset_combiner_checker.sv
// Assertion checker for the reset combiner ports.
`timescale 1ns/1ps
module reset_combiner_checker
    import reset_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   reset_n,
    input wire reset_requests_t        requests,
    input wire logic                   power_up_delay_disable_n,
    input wire logic                   core_reset,
    input wire logic [NUM_SOURCES-1:0] reset_cause
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire supply_low = requests[8] | requests[7] | requests[6];
    // The first edge after reset still shows the cleared cause register, so it is skipped.
    property p_any; $past(reset_n) && $past(requests, 3) != '0 |-> core_reset; endproperty
    a_any: assert property (p_any) else $error("core reset missed a request");
    property p_pon; $past(reset_n) && $past(requests.power_on_detect, 3) |-> reset_cause[0];
    endproperty
    a_pon: assert property (p_pon) else $error("power-on cause missing");
    property p_bor; $past(reset_n) && $past(requests[7] | requests[6], 3) |-> reset_cause[1];
    endproperty
    a_bor: assert property (p_bor) else $error("brown-out cause missing");
    property p_external_master_clear;
        $past(reset_n) && $past(requests.external_master_clear, 3) |-> reset_cause[3];
    endproperty
    a_external_master_clear: assert property (p_external_master_clear) else $error("master clear cause missing");
    property p_hold; reset_cause[9] |-> core_reset; endproperty
    a_hold: assert property (p_hold) else $error("core left reset while timer runs");
    property p_start;
        $fell(supply_low) && !power_up_delay_disable_n
            ##1 (!supply_low && !power_up_delay_disable_n) [*6] |-> reset_cause[9] && core_reset;
    endproperty
    a_start: assert property (p_start) else $error("delay did not start");
    property p_bypass;
        $fell(supply_low) && power_up_delay_disable_n
            ##1 (!supply_low && power_up_delay_disable_n) [*8] |-> !reset_cause[9];
    endproperty
    a_bypass: assert property (p_bypass) else $error("delay ran while bypassed");
    property p_release; reset_cause == '0 && $past(reset_n) |-> !core_reset; endproperty
    a_release: assert property (p_release) else $error("reset held without cause");
    c_start: cover property ($rose(reset_cause[9]));
    c_release: cover property ($fell(core_reset));
    c_restart: cover property (reset_cause[9] && supply_low);
endmodule

// File: tb/test_reset_combiner.sv
// Self-checking bench for the reset combiner.
`timescale 1ns/1ps
module test_reset_combiner;
    import reset_pkg::*;
    logic                   clk_sys = 0;
    logic                   reset_n = 0;
    logic                   dis_n = 1;
    logic                   core_reset;
    logic [NUM_SOURCES-1:0] reset_cause;
    reset_requests_t        requests, h1, h2, h3;
    logic                   pud = 0, live = 0;
    int                     n_mismatch = 0, checks = 0, q = 0, cyc = 0;
    always #2 clk_sys = ~clk_sys;
    reset_request_model reset_request_model_i (.clk_sys(clk_sys), .requests(requests));
    reset_combiner reset_combiner_i (.clk_sys(clk_sys), .reset_n(reset_n), .requests(requests),
        .power_up_delay_disable_n(dis_n), .core_reset(core_reset), .reset_cause(reset_cause));
    function automatic logic sup(reset_requests_t r);
        return r[8] | r[7] | r[6];
    endfunction
    function automatic logic [8:0] cause_of(reset_requests_t r);
        return {r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7] | r[6], r[8]};
    endfunction
    task automatic stop_test;
        if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(string nm, logic [8:0] e, logic [8:0] s);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // The model waits ten quiet cycles before judging the timer, since four flops sit between a request and reset_cause.
    always @(posedge clk_sys) begin
        live <= reset_n;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
        if (!reset_n) begin
            h1 <= '1;
            h2 <= '1;
            h3 <= '1;
            q <= 0;
        end else begin
            h1 <= requests;
            h2 <= h1;
            h3 <= h2;
            q <= (sup(requests) != sup(h1)) ? 0 : q + 1;
            if (sup(h1) && !sup(requests)) pud <= !dis_n;
        end
    end
    always @(negedge clk_sys) if (live) begin
        cmp("reset_cause", cause_of(h3), reset_cause[8:0]);
        if (q >= 10) cmp("core_reset", {8'h0, |cause_of(h3) | pud}, {8'h0, core_reset});
        if (q >= 10 && !sup(h3)) cmp("timer", {8'h0, pud}, {8'h0, reset_cause[9]});
    end
    initial begin
        void'($urandom(32'hdefc));
        repeat (20) @(negedge clk_sys);
        reset_n = 1;
        for (int i = 0; i < 9; i++) begin
            reset_request_model_i.apply(9'h1 << i, 6);
            reset_request_model_i.apply('0, 12);
        end
        repeat (60) reset_request_model_i.apply(9'($urandom), $urandom_range(1, 14));
        reset_request_model_i.apply(9'h100, 10);
        dis_n = 0;
        reset_request_model_i.apply(9'h100, 10);
        reset_request_model_i.apply('0, 300);
        reset_request_model_i.apply(9'h080, 5);
        reset_request_model_i.apply(9'h020, 20);
        dis_n = 1;
        reset_request_model_i.apply('0, 300);
        reset_n = 0;
        reset_request_model_i.apply('0, 5);
        reset_n = 1;
        reset_request_model_i.apply('0, 40);
        stop_test();
    end
endmodule
bind reset_combiner reset_combiner_checker reset_combiner_checker_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .requests(requests), .power_up_delay_disable_n(power_up_delay_disable_n),
    .core_reset(core_reset), .reset_cause(reset_cause));
